// file: core/adcr_pkg.sv
/*
 * Package for the converter control and result block: register offsets,
 * field positions, reset values, timing counts and bus carrier types.
 * Assumes an APB master with 32-bit data, one register per aligned word.
 */
// Functional notes
// [RL1] Result high byte bits 7..2 read zero
// [RL2] Result bits 9..8 in high byte bits 1..0
// [RL3] Result bits 7..0 in low byte register
// [RL4] Software waits acquisition time before start
// [RL5] Ten-bit unsigned result, 1024 codes
// [RL6] Control zero: channel 6..2, start 1, on 0
// [RL7] Done flag and enable at bit 6
// [RL8] Control one: clock select bits 6..4
// [RL9] Start bit set by write, cleared at done
// [RL10] Converter off when on bit is zero
// [RL11] Load result, then set sticky done flag
package adcr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL0  = 8'h00;
    localparam logic [7:0] OFF_CTRL1  = 8'h04;
    localparam logic [7:0] OFF_RESH   = 8'h08;
    localparam logic [7:0] OFF_RESL   = 8'h0C;
    localparam logic [7:0] OFF_FLAGS2 = 8'h10;
    localparam logic [7:0] OFF_ENAB2  = 8'h14;
    // Field positions
    localparam int CH_LSB    = 2;
    localparam int CH_MSB    = 6;
    localparam int START_BIT = 1;
    localparam int ON_BIT    = 0;
    localparam int CKS_LSB   = 4;
    localparam int CKS_MSB   = 6;
    localparam int REF_BIT   = 0;
    localparam int DONE_BIT  = 6;
    // Result width and reset values
    localparam int RES_W = 10;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Clock selector codes
    localparam logic [2:0] CKS_DIV8  = 3'h1;
    localparam logic [2:0] CKS_DIV32 = 3'h2;
    localparam logic [2:0] CKS_DIV16 = 3'h5;
    localparam logic [2:0] CKS_DIV64 = 3'h6;
    // Divider ratios and internal-oscillator ratio for x11 codes
    localparam logic [6:0] DIV_8  = 7'h08;
    localparam logic [6:0] DIV_16 = 7'h10;
    localparam logic [6:0] DIV_32 = 7'h20;
    localparam logic [6:0] DIV_64 = 7'h40;
    localparam logic [6:0] DIV_RC = 7'h10;
    // Conversion takes one tick per bit plus one for the sample
    localparam logic [3:0] CONV_TICKS = 4'hB;

    // APB request carrier
    typedef struct packed {
        logic        sel;
        logic        en;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } adcr_apb_req_t;
endpackage

// file: core/adcr_tick_div.sv
/*
 * Programmable divider: one-cycle tick every ratio pclk cycles.
 * Assumes ratio is stable while run is high.
 */
`timescale 1ns/1ps
module adcr_tick_div (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [6:0] ratio,
    output logic            tick
);
    logic [6:0] cnt_r;   // Cycle counter
    logic [6:0] cnt_nxt; // Next count

    // Count up to ratio-1 then wrap with a tick
    always_comb begin
        tick    = 1'b0;
        cnt_nxt = cnt_r;
        if (!run) begin
            cnt_nxt = 7'h00;
        end else if (cnt_r == ratio - 7'h01) begin
            cnt_nxt = 7'h00;
            tick    = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 7'h01;
        end
    end

    // Counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 7'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// file: core/adcr_top.sv
/*
 * Converter control and result block with APB register slave.
 * Assumes the analog side resolves a sample into sample_code, valid when
 * the conversion finishes; one pclk domain, zero-wait APB answers.
 * Result registers reset to zero so that reads are never unknown,
 * although their contents only mean something after a conversion.
 * Software must let the input settle after a channel change.
 */
`timescale 1ns/1ps
module adcr_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [9:0]  sample_code,
    output logic [4:0]       channel_selector,
    output logic             converter_on,
    output logic             reference_select,
    output logic             sample_hold,
    output logic             conversion_done_flag,
    output logic             conversion_done_enable
);
    // Sequencer states: waiting for a start, or converting
    typedef enum logic [1:0] {ST_IDLE, ST_CONV} adcr_state_t;

    adcr_pkg::adcr_apb_req_t req;   // Bundled bus request
    adcr_state_t state_r, state_nxt; // Conversion sequencer
    logic [4:0] chan_r, chan_nxt;    // Channel selector
    logic       on_r, on_nxt;        // Converter enable
    logic       go_r, go_nxt;        // Start/status bit
    logic [2:0] cks_r, cks_nxt;      // Conversion clock select
    logic       ref_r, ref_nxt;      // Reference select
    logic [9:0] res_r, res_nxt;      // Conversion result
    logic       flag_r, flag_nxt;    // Sticky done flag
    logic       ie_r, ie_nxt;        // Done enable
    logic [3:0] tcnt_r, tcnt_nxt;    // Conversion tick count
    logic [6:0] ratio;               // Divider ratio
    logic       tick;                // Conversion clock enable
    logic       wr_acc;              // Write access edge
    logic       finish;              // Last conversion tick

    // Bundle the bus pins into the package carrier
    assign req = '{sel: psel, en: penable, write: pwrite,
                   addr: paddr, wdata: pwdata};
    // A write takes effect in the access phase only
    assign wr_acc  = req.sel && req.en && req.write;
    assign pready  = 1'b1;           // Zero wait states
    assign pslverr = 1'b0;           // Unmapped reads give zero

    // Clock selector picks the conversion tick ratio
    // Reserved codes fall back to the internal-oscillator ratio, so a
    // bad setting still converts, only at another rate
    always_comb begin
        case (cks_r)
            adcr_pkg::CKS_DIV8:  ratio = adcr_pkg::DIV_8;
            adcr_pkg::CKS_DIV16: ratio = adcr_pkg::DIV_16;
            adcr_pkg::CKS_DIV32: ratio = adcr_pkg::DIV_32;
            adcr_pkg::CKS_DIV64: ratio = adcr_pkg::DIV_64;
            default:             ratio = adcr_pkg::DIV_RC; // Reserved too
        endcase
    end

    // Divider runs only while converting, so the first tick always
    // comes a full period after the start, whatever ran before
    adcr_tick_div u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (state_r == ST_CONV),
        .ratio   (ratio),
        .tick    (tick)
    );

    // Last tick of a conversion; the count runs 0 to CONV_TICKS-1
    assign finish = tick && (tcnt_r == adcr_pkg::CONV_TICKS - 4'h1);

    // Next values of registers and sequencer
    always_comb begin
        // Hold every register unless a branch below changes it
        state_nxt = state_r;
        chan_nxt  = chan_r;
        on_nxt    = on_r;
        go_nxt    = go_r;
        cks_nxt   = cks_r;
        ref_nxt   = ref_r;
        res_nxt   = res_r;
        flag_nxt  = flag_r;
        ie_nxt    = ie_r;
        tcnt_nxt  = tcnt_r;
        // Register writes first, so the sequencer below can override
        // them: a hardware set of the flag must beat a software clear
        if (wr_acc) begin
            case (req.addr)
                adcr_pkg::OFF_CTRL0: begin
                    // Control zero fields; see [RL6]
                    chan_nxt = req.wdata[adcr_pkg::CH_MSB:adcr_pkg::CH_LSB];
                    on_nxt   = req.wdata[adcr_pkg::ON_BIT];
                    // Software may set start, never clear it; see [RL9]
                    if (req.wdata[adcr_pkg::START_BIT]) begin
                        go_nxt = 1'b1;
                    end
                end
                adcr_pkg::OFF_CTRL1: begin
                    // Control one fields; see [RL8]
                    cks_nxt = req.wdata[adcr_pkg::CKS_MSB:adcr_pkg::CKS_LSB];
                    ref_nxt = req.wdata[adcr_pkg::REF_BIT];
                end
                adcr_pkg::OFF_FLAGS2: begin
                    // Software clears the flag by writing zero
                    flag_nxt = req.wdata[adcr_pkg::DONE_BIT];
                end
                adcr_pkg::OFF_ENAB2: begin
                    ie_nxt = req.wdata[adcr_pkg::DONE_BIT]; // see [RL7]
                end
                default: begin
                    // Result and unmapped offsets ignore writes
                end
            endcase
        end
        // Conversion sequencer
        case (state_r)
            ST_IDLE: begin
                tcnt_nxt = 4'h0;
                // Start only when the converter is on; see [RL10]
                if (go_r && on_r) begin
                    state_nxt = ST_CONV;
                end else if (!on_nxt) begin
                    // Checking the value being written, not the stored
                    // one, lets a single write switch on and start
                    go_nxt = 1'b0;
                end
            end
            ST_CONV: begin
                if (!on_r) begin
                    // Switching off aborts with no result; see [RL10]
                    state_nxt = ST_IDLE;
                    go_nxt    = 1'b0;
                end else if (finish) begin
                    // Load ten-bit code then flag it; see [RL5] [RL11]
                    res_nxt   = sample_code;
                    flag_nxt  = 1'b1;   // Set beats clear; see [RL11]
                    go_nxt    = 1'b0;   // see [RL9]
                    state_nxt = ST_IDLE;
                end else if (tick) begin
                    // Count ticks up to the last one
                    tcnt_nxt = tcnt_r + 4'h1;
                end
            end
            // Unused codes fall back to idle
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State registers; result is cleared only for determinism
    // Reset branch loads constants only, so the reset path never
    // depends on other flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            chan_r  <= 5'h00;
            on_r    <= 1'b0;
            go_r    <= 1'b0;
            cks_r   <= 3'h0;
            ref_r   <= 1'b0;
            res_r   <= 10'h000;
            flag_r  <= 1'b0;
            ie_r    <= 1'b0;
            tcnt_r  <= 4'h0;
        end else begin
            state_r <= state_nxt;
            chan_r  <= chan_nxt;
            on_r    <= on_nxt;
            go_r    <= go_nxt;
            cks_r   <= cks_nxt;
            ref_r   <= ref_nxt;
            res_r   <= res_nxt;
            flag_r  <= flag_nxt;
            ie_r    <= ie_nxt;
            tcnt_r  <= tcnt_nxt;
        end
    end

    // Read mux: unused bits read zero
    // Decoded on psel and pwrite, not penable, so data already stand in the setup
    // phase and stay unchanged through the access phase
    always_comb begin
        prdata = 32'h0000_0000;
        if (req.sel && !req.write) begin
            case (req.addr)
                adcr_pkg::OFF_CTRL0: begin
                    // Bit 7 stays zero; see [RL6]
                    prdata[adcr_pkg::CH_MSB:adcr_pkg::CH_LSB] = chan_r;
                    prdata[adcr_pkg::START_BIT] = go_r;
                    prdata[adcr_pkg::ON_BIT]    = on_r;
                end
                adcr_pkg::OFF_CTRL1: begin
                    // Bits 7 and 3..1 stay zero; see [RL8]
                    prdata[adcr_pkg::CKS_MSB:adcr_pkg::CKS_LSB] = cks_r;
                    prdata[adcr_pkg::REF_BIT] = ref_r;
                end
                // Upper six bits stay zero; see [RL1] [RL2]
                adcr_pkg::OFF_RESH: prdata[1:0] = res_r[9:8];
                adcr_pkg::OFF_RESL: prdata[7:0] = res_r[7:0]; // see [RL3]
                // Flag and enable both sit at bit 6; see [RL7]
                adcr_pkg::OFF_FLAGS2: prdata[adcr_pkg::DONE_BIT] = flag_r;
                adcr_pkg::OFF_ENAB2:  prdata[adcr_pkg::DONE_BIT] = ie_r;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // Pins follow the registers directly, with no extra delay
    assign channel_selector       = chan_r;
    assign converter_on           = on_r;
    assign reference_select       = ref_r;
    assign sample_hold            = (state_r == ST_CONV);
    assign conversion_done_flag   = flag_r;
    assign conversion_done_enable = ie_r;
endmodule

// file: tb/adcr_chk_sva.sv
/* Port checker for adcr_top: register padding, start and stop of
   conversions, done flag. Assumes one pclk domain, bound below. */
`timescale 1ns/1ps
module adcr_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [4:0]  channel_selector,
    input wire logic        converter_on,
    input wire logic        sample_hold,
    input wire logic        conversion_done_flag
);
    // One domain, so one clock and one disable for all
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic rd_any = psel && !pwrite;  // Read presented
    wire logic wr_acc = psel && penable && pwrite;  // Write taken
    wire logic c0_wr  = wr_acc && paddr == adcr_pkg::OFF_CTRL0;
    wire logic fl_wr  = wr_acc && paddr == adcr_pkg::OFF_FLAGS2;
    // Channel field of the write data, so $past sees a plain signal
    wire logic [4:0] wr_chan = pwdata[adcr_pkg::CH_MSB:adcr_pkg::CH_LSB];
    resh_pad_a: assert property (
        rd_any && paddr == adcr_pkg::OFF_RESH |-> prdata[31:2] == '0)
        else $error("high result byte padding not zero");
    ctrl0_pad_a: assert property (
        rd_any && paddr == adcr_pkg::OFF_CTRL0 |-> !prdata[7])
        else $error("control zero bit 7 not zero");
    ctrl1_pad_a: assert property (
        rd_any && paddr == adcr_pkg::OFF_CTRL1 |-> !prdata[7] &&
        prdata[3:1] == 3'h0) else $error("control one padding not zero");
    chan_load_a: assert property (
        c0_wr |=> channel_selector == $past(wr_chan))
        else $error("channel selector not loaded");
    start_conv_a: assert property (
        c0_wr && pwdata[1:0] == 2'h3 && !sample_hold |-> ##[1:2] sample_hold)
        else $error("conversion did not start");
    conv_hold_a: assert property (
        $rose(sample_hold) |-> sample_hold[*8])
        else $error("conversion ended too soon");
    off_stop_a: assert property (
        !converter_on |-> ##[0:2] !sample_hold)
        else $error("converter off but still converting");
    done_set_a: assert property (
        $fell(sample_hold) && converter_on |-> conversion_done_flag)
        else $error("done flag not set at finish");
    flag_cause_a: assert property (
        $rose(conversion_done_flag) |-> $past(sample_hold) || $past(fl_wr))
        else $error("done flag set without cause");
    flag_keep_a: assert property (
        conversion_done_flag && !fl_wr |=> conversion_done_flag)
        else $error("done flag dropped without a clear");
endmodule
bind adcr_top adcr_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .channel_selector(channel_selector),
    .converter_on(converter_on), .sample_hold(sample_hold),
    .conversion_done_flag(conversion_done_flag));

// file: tb/adcr_analog.sv
/* Analog side model: turns a bench level and the channel into a code.
   Assumes the bench sets the level before each start. */
`timescale 1ns/1ps
module adcr_analog (
    input  wire logic [9:0] level,
    input  wire logic [4:0] channel_selector,
    input  wire logic       converter_on,
    input  wire logic       sample_hold,
    output logic [9:0]      sample_code
);
    // Each channel node differs; idle output inverted so stale reads fail
    always_comb begin
        if (sample_hold && converter_on) begin
            sample_code = level ^ {5'h00, channel_selector};
        end else begin
            sample_code = ~level;
        end
    end
endmodule

// file: tb/adcr_result_and_control_test.sv
/* Bench for adcr_top: APB tasks, analog model, queued read checks.
   Assumes a zero-wait APB slave at the package offsets. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    mismatches++; $display("unexpected %0t %h vs %h", $time, a, b); end end
module adcr_result_and_control_test;
    logic                    pclk = 1'b0;
    logic                    presetn = 1'b0;
    adcr_pkg::adcr_apb_req_t req = '0;  // APB request
    logic [31:0]             prdata;
    logic                    pready, hold, on, flag;
    logic                    ie, rsel, perr;  // Enable, reference, error
    logic [31:0]             note;  // Oldest expected read value
    logic [4:0]              chan, ch;
    logic [9:0]              level = '0, code, exp;
    logic [31:0]             q[$];  // Expected read data, oldest first
    int                      mismatches = 0, n_compared = 0, n;
    logic [2:0]  cks[6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    logic [6:0]  rt[6] = '{7'h08, 7'h10, 7'h20, 7'h40, 7'h10, 7'h10};
    adcr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(req.sel),
        .penable(req.en), .pwrite(req.write), .paddr(req.addr),
        .pwdata(req.wdata), .prdata(prdata), .pready(pready),
        .pslverr(perr), .sample_code(code), .channel_selector(chan),
        .converter_on(on), .reference_select(rsel), .sample_hold(hold),
        .conversion_done_flag(flag), .conversion_done_enable(ie));
    adcr_analog u_ana (.level(level), .channel_selector(chan),
        .converter_on(on), .sample_hold(hold), .sample_code(code));
    initial forever #4 pclk = ~pclk;
    // One transfer; idle edge after so strobes never double-assign
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.en <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        req <= '0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        xfer(1'b0, a, '0);
    endtask
    // Bounded wait on the done flag, cycles waited in n
    task automatic wait_done;
        n = 0;
        while (flag !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // Read data checked at the edge the master takes it
    always @(posedge pclk) begin
        if (req.sel && req.en && !req.write && pready === 1'b1) begin
            // Pop once, so a mismatch cannot skip a note
            note = q.pop_front();
            `CHK(prdata, note)
        end
    end
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard, well past the expected run
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h7C7DE1EE));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(adcr_pkg::OFF_CTRL0, '0);
        rd(adcr_pkg::OFF_FLAGS2, '0);
        rd(8'h18, '0);
        xfer(1'b1, adcr_pkg::OFF_CTRL1, '1);
        rd(adcr_pkg::OFF_CTRL1, 32'h00000071);
        xfer(1'b1, adcr_pkg::OFF_ENAB2, '1);
        rd(adcr_pkg::OFF_ENAB2, 32'h00000040);
        `CHK({ie, rsel, perr}, 3'h6)
        $display("test registers done");
        // Every clock selector code except 0 and 4, random channel and level
        for (int i = 0; i < 6; i++) begin
            ch = 5'($urandom);
            xfer(1'b1, adcr_pkg::OFF_CTRL1, {25'h0, cks[i], 4'h0});
            `CHK(rsel, 1'b0)
            xfer(1'b1, adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h1});
            repeat (40) @(posedge pclk);
            level <= 10'($urandom);
            xfer(1'b1, adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h3});
            wait_done();
            `CHK(n >= 11 * rt[i] - 2 && n <= 11 * rt[i] + 6, 1'b1)
            exp = level ^ {5'h00, ch};
            rd(adcr_pkg::OFF_RESH, {30'h0, exp[9:8]});
            xfer(1'b1, adcr_pkg::OFF_RESL, '1);
            rd(adcr_pkg::OFF_RESL, {24'h0, exp[7:0]});
            rd(adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h1});
            rd(adcr_pkg::OFF_FLAGS2, 32'h00000040);
            xfer(1'b1, adcr_pkg::OFF_FLAGS2, '0);
            rd(adcr_pkg::OFF_FLAGS2, '0);
        end
        $display("test conversions done");
        // Clearing the enable mid-conversion drops the result
        xfer(1'b1, adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h3});
        rd(adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h3});
        repeat (20) @(posedge pclk);
        xfer(1'b1, adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h0});
        repeat (400) @(posedge pclk);
        `CHK(flag, 1'b0)
        xfer(1'b1, adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h2});
        rd(adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h0});
        $display("test abort done");
        // One write both switches the converter on and starts it
        level <= 10'($urandom);
        xfer(1'b1, adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h3});
        wait_done();
        `CHK(flag, 1'b1)
        exp = level ^ {5'h00, ch};
        rd(adcr_pkg::OFF_RESL, {24'h0, exp[7:0]});
        rd(adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h1});
        $display("test single write start done");
        // Reset in mid-conversion returns registers to reset values
        xfer(1'b1, adcr_pkg::OFF_CTRL0, {25'h0, ch, 2'h3});
        repeat (10) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK({hold, on, flag, ie, rsel}, 5'h00)
        presetn <= 1'b1;
        @(posedge pclk);
        rd(adcr_pkg::OFF_CTRL0, '0);
        rd(adcr_pkg::OFF_CTRL1, '0);
        rd(adcr_pkg::OFF_ENAB2, '0);
        $display("test reset done");
        tally_and_finish();
    end
endmodule
